// File: hw/eil_pkg.sv
package eil_pkg;

	// Widths of the plain register port.
	localparam int EIL_ADDR_W = 8;
	localparam int EIL_DATA_W = 8;

	// Register offsets on the plain register port.
	localparam logic [EIL_ADDR_W-1:0] EIL_OFS_STATUS = 8'h00;
	localparam logic [EIL_ADDR_W-1:0] EIL_OFS_BREAK = 8'h01;

	// Field positions inside the status and control register.
	localparam int EIL_BIT_MODE = 0;
	localparam int EIL_BIT_MASK = 1;
	localparam int EIL_BIT_ACK = 2;
	localparam int EIL_BIT_PEND = 3;

	// Field position inside the break flag control register.
	localparam int EIL_BIT_BCE = 7;

	// Reset values of the software fields.
	localparam logic EIL_RST_MODE = 1'b0;
	localparam logic EIL_RST_MASK = 1'b0;
	localparam logic EIL_RST_BCE = 1'b0;

	// The pin idles high through its pullup, so the sampling stages reset high.
	localparam logic EIL_RST_PIN = 1'b1;

	// Vector pair from which the processor loads its program counter.
	localparam logic [15:0] EIL_VEC_HI_ADDR = 16'hFFFA;
	localparam logic [15:0] EIL_VEC_LO_ADDR = 16'hFFFB;

	// Request latch states.
	typedef enum logic [1:0]
	{
		EIL_IDLE = 2'b00,
		EIL_PEND = 2'b01,
		EIL_ACKD = 2'b10
	} eil_state_type;

endpackage

// File: hw/eil_pin_if.sv
`timescale 1ns/10ps

// Carries the sampled pin level and its falling-edge pulse to the latch logic.
interface eil_pin_if;
	logic pin_level;
	logic pin_fall;

	modport src
	(
		output pin_level,
		output pin_fall
	);

	modport dst
	(
		input pin_level,
		input pin_fall
	);
endinterface

// File: hw/eil_pin_sync.sv
`timescale 1ns/10ps

// Brings the active-low pin into the bus clock domain and finds its falling edges.
module eil_pin_sync
	import eil_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic irq_pin_n,
	eil_pin_if.src pin
);

	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;
	logic prev_q;
	logic prev_d;

	// Shift the pin through two stages, then keep one older sample for the edge.
	always_comb
	begin
		meta_d = irq_pin_n;
		sync_d = meta_q;
		prev_d = sync_q;
	end

	// The first stage feeds only the second stage.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			meta_q <= EIL_RST_PIN;
			sync_q <= EIL_RST_PIN;
			prev_q <= EIL_RST_PIN;
		end
		else if (clk_en)
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			prev_q <= prev_d;
		end
	end

	// A high sample followed by a low sample one bus clock later is a falling edge.
	assign pin.pin_level = sync_q;
	assign pin.pin_fall = prev_q & ~sync_q;

endmodule

// File: hw/eil_top.sv
`timescale 1ns/10ps

module eil_top
	import eil_pkg::*;
#(
	parameter int ADDR_W = EIL_ADDR_W,
	parameter int DATA_W = EIL_DATA_W
)
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic irq_pin_n,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	input wire logic break_state,
	input wire logic vector_fetch_ack,
	output logic irq_request,
	output logic pending_flag,
	output logic pin_level,
	output logic [15:0] vector_hi_addr,
	output logic [15:0] vector_lo_addr
);

	// True when an access address selects the given register.
	function automatic logic eil_hit(input logic [ADDR_W-1:0] addr,
		input logic [EIL_ADDR_W-1:0] ofs);
		eil_hit = (addr == ADDR_W'(ofs));
	endfunction

	eil_pin_if pin ();

	logic pin_low;
	logic pin_fall;
	logic sel_status;
	logic sel_break;
	logic sw_ack;
	logic sw_ack_eff;
	logic any_ack;
	logic set_req;
	logic mode_q;
	logic mode_d;
	logic mask_q;
	logic mask_d;
	logic bce_q;
	logic bce_d;
	eil_state_type state_q;
	eil_state_type state_d;
	logic [DATA_W-1:0] rdata_q;
	logic [DATA_W-1:0] rdata_d;
	logic [15:0] vec_hi_q;
	logic [15:0] vec_lo_q;

	// Pin sampling and edge detection.
	eil_pin_sync u_pin_sync
	(
		.core_clk(core_clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.irq_pin_n(irq_pin_n),
		.pin(pin)
	);

	// Decode of the synchronised pin and of register accesses.
	always_comb
	begin
		pin_low = ~pin.pin_level;
		pin_fall = pin.pin_fall;
		sel_status = eil_hit(reg_addr, EIL_OFS_STATUS);
		sel_break = eil_hit(reg_addr, EIL_OFS_BREAK);
		sw_ack = reg_wr & sel_status & reg_wdata[EIL_BIT_ACK];
	end

	// Acknowledge sources and trigger condition for the latch.
	always_comb
	begin
		// During a break, software acknowledges count only with break clear enabled.
		sw_ack_eff = sw_ack & (~break_state | bce_q);
		any_ack = vector_fetch_ack | sw_ack_eff;
		// Level mode adds the low pin level to the falling edge.
		set_req = pin_fall | (mode_q & pin_low);
	end

	// Software fields: sensitivity, mask and break clear enable.
	always_comb
	begin
		mode_d = mode_q;
		mask_d = mask_q;
		bce_d = bce_q;
		if (reg_wr && sel_status)
		begin
			mode_d = reg_wdata[EIL_BIT_MODE];
			mask_d = reg_wdata[EIL_BIT_MASK];
		end
		if (reg_wr && sel_break)
		begin
			bce_d = reg_wdata[EIL_BIT_BCE];
		end
	end

	// Reset leaves the pin edge sensitive, unmasked and the latch protected in break.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			mode_q <= EIL_RST_MODE;
			mask_q <= EIL_RST_MASK;
			bce_q <= EIL_RST_BCE;
		end
		else if (clk_en)
		begin
			mode_q <= mode_d;
			mask_q <= mask_d;
			bce_q <= bce_d;
		end
	end

	// Request latch: pending, or acknowledged but held by a low pin in level mode.
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			EIL_IDLE:
			begin
				if (set_req)
				begin
					state_d = EIL_PEND;
				end
			end
			EIL_PEND:
			begin
				// A new edge in the same cycle as an acknowledge keeps the request.
				if (pin_fall)
				begin
					state_d = EIL_PEND;
				end
				else if (any_ack && mode_q && pin_low)
				begin
					state_d = EIL_ACKD;
				end
				else if (any_ack)
				begin
					state_d = EIL_IDLE;
				end
			end
			EIL_ACKD:
			begin
				// The acknowledge is already in; only the pin level holds the request.
				if (pin_fall)
				begin
					state_d = EIL_PEND;
				end
				else if (!mode_q || !pin_low)
				begin
					state_d = EIL_IDLE;
				end
			end
			default:
			begin
				state_d = EIL_IDLE;
			end
		endcase
	end

	// Reset empties the latch whatever the pin shows.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_q <= EIL_IDLE;
		end
		else if (clk_en)
		begin
			state_q <= state_d;
		end
	end

	// Read data for the cycle after a read strobe; unmapped addresses read zero.
	always_comb
	begin
		rdata_d = '0;
		if (reg_rd && sel_status)
		begin
			rdata_d[EIL_BIT_MODE] = mode_q;
			rdata_d[EIL_BIT_MASK] = mask_q;
			rdata_d[EIL_BIT_ACK] = 1'b0;
			rdata_d[EIL_BIT_PEND] = (state_q != EIL_IDLE);
		end
		else if (reg_rd && sel_break)
		begin
			rdata_d[EIL_BIT_BCE] = bce_q;
		end
	end

	// Read data register; it also holds the vector pair offered to the processor.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rdata_q <= '0;
			vec_hi_q <= EIL_VEC_HI_ADDR;
			vec_lo_q <= EIL_VEC_LO_ADDR;
		end
		else if (clk_en)
		begin
			rdata_q <= rdata_d;
			vec_hi_q <= EIL_VEC_HI_ADDR;
			vec_lo_q <= EIL_VEC_LO_ADDR;
		end
	end

	// Outputs; the mask gates the request but never the pending flag.
	assign reg_rdata = rdata_q;
	assign pending_flag = (state_q != EIL_IDLE);
	assign irq_request = (state_q != EIL_IDLE) & ~mask_q;
	assign pin_level = pin.pin_level;
	assign vector_hi_addr = vec_hi_q;
	assign vector_lo_addr = vec_lo_q;

	default clocking cb @(posedge core_clk);
	endclocking

	default disable iff (!resetn);

	// A falling edge leaves a pending flag and, unmasked, a request.
	fall_sets_a: assert property (clk_en && pin_fall |=> pending_flag && (irq_request == !mask_q))
		else $error("falling edge did not set the latch");

	// A vector fetch in edge-only mode clears the latch in the next cycle.
	vec_ack_clear_a: assert property (clk_en && vector_fetch_ack && !mode_q && !pin_fall
		|=> !pending_flag)
		else $error("vector fetch did not clear the latch");

	// A software acknowledge outside break in edge-only mode clears at once.
	sw_ack_clear_a: assert property (clk_en && reg_wr && sel_status && reg_wdata[EIL_BIT_ACK]
		&& !break_state && !reg_wdata[EIL_BIT_MODE] && !mode_q && !pin_fall |=> !pending_flag)
		else $error("software acknowledge did not clear the latch");

	// In level mode a low pin holds the request through a vector fetch acknowledge; status writes are left out.
	level_hold_a: assert property (clk_en && mode_q && pin_low && !(reg_wr && sel_status)
		|=> pending_flag)
		else $error("request dropped while pin low in level mode");

	// After acknowledge and a high pin in level mode the request ends.
	level_release_a: assert property (clk_en && state_q == EIL_ACKD && !pin_low && !pin_fall
		|=> state_q == EIL_IDLE)
		else $error("acknowledged request not released on high pin");

	// The mask blocks forwarding but keeps the pending flag.
	mask_gate_a: assert property (mask_q |-> !irq_request)
		else $error("masked request forwarded");

	// Pending flag reads back one cycle later, acknowledge bit as zero.
	pend_read_a: assert property (clk_en && reg_rd && sel_status
		|=> reg_rdata[EIL_BIT_PEND] == $past(pending_flag) && !reg_rdata[EIL_BIT_ACK])
		else $error("status read data wrong");

	// With break clear disabled, an acknowledge in break leaves the latch set.
	// A held level request may still end by the pin going high, so only the set latch counts.
	break_protect_a: assert property (clk_en && pending_flag && sw_ack && break_state
		&& !bce_q && !vector_fetch_ack && state_q == EIL_PEND |=> pending_flag)
		else $error("latch cleared during protected break");

	// With break clear enabled, an acknowledge in break clears in edge-only mode.
	break_clear_a: assert property (clk_en && sw_ack && break_state && bce_q && !mode_q
		&& !reg_wdata[EIL_BIT_MODE] && !pin_fall |=> !pending_flag)
		else $error("break acknowledge did not clear the latch");

	// A low clock enable freezes the latch, the software fields and the pin sampler.
	freeze_hold_a: assert property (!clk_en |=> $stable(state_q) && $stable(mode_q)
		&& $stable(mask_q) && $stable(bce_q) && $stable(reg_rdata) && $stable(pin_level))
		else $error("state moved while clock enable was low");

	// An unmasked pending request always reaches the priority logic.
	mask_forward_a: assert property (pending_flag && !mask_q |-> irq_request)
		else $error("unmasked request not forwarded");

	// In edge-only mode a low level without a new edge never sets the latch.
	edge_only_a: assert property (clk_en && !mode_q && !pin_fall && !pending_flag
		|=> !pending_flag)
		else $error("latch set without a falling edge");

	// A status read returns the mask and sensitivity bits as they stood.
	status_fields_a: assert property (clk_en && reg_rd && sel_status |=>
		reg_rdata[EIL_BIT_MASK] == $past(mask_q) && reg_rdata[EIL_BIT_MODE] == $past(mode_q))
		else $error("status read lost mask or mode");

	// A break register read returns the break clear enable bit.
	bce_read_a: assert property (clk_en && reg_rd && sel_break
		|=> reg_rdata[EIL_BIT_BCE] == $past(bce_q))
		else $error("break register read wrong");

	// Without a read the data port falls back to zero after its one cycle.
	rdata_idle_a: assert property (clk_en && !reg_rd |=> reg_rdata == '0)
		else $error("read data stood longer than one cycle");

	// A status write always updates the mask and the sensitivity bits.
	field_write_a: assert property (clk_en && reg_wr && sel_status |=>
		mask_q == $past(reg_wdata[EIL_BIT_MASK]) && mode_q == $past(reg_wdata[EIL_BIT_MODE]))
		else $error("status write did not reach mask or mode");

	// The vector pair offered to the processor never changes.
	vec_const_a: assert property (vector_hi_addr == EIL_VEC_HI_ADDR
		&& vector_lo_addr == EIL_VEC_LO_ADDR)
		else $error("vector pair changed");

	// The pin level seen by branch instructions lags the pin by two enabled clocks.
	pin_follow_a: assert property (clk_en ##1 clk_en
		|=> pin_level == $past(irq_pin_n, 2))
		else $error("pin level does not follow the pin");

	// A high synchronised sample followed by a low one raises the edge pulse.
	fall_detect_a: assert property (clk_en && pin_level ##1 !pin_level |-> pin_fall)
		else $error("falling edge not detected");

	// An acknowledge never swallows a falling edge that arrives beside it.
	ack_edge_a: assert property (clk_en && pin_fall && (vector_fetch_ack || sw_ack)
		|=> pending_flag)
		else $error("edge lost beside an acknowledge");

endmodule

// File: sim/eil_src_model.sv
`timescale 1ns/10ps

// External interrupt source: pulls the pin low on command, else the pullup holds it high.
module eil_src_model
(
	input wire logic drive_low,
	output logic irq_pin_n
);
	// A released line is pulled high, never left at its last value.
	assign irq_pin_n = drive_low ? 1'b0 : 1'b1;
endmodule

// File: sim/eil_top_tb_top.sv
`timescale 1ns/10ps

// Register-level tests of the external interrupt latch.
module eil_top_tb_top;
	import eil_pkg::*;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic clk_en = 1'b1;
	logic drive_low = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic break_state = 1'b0;
	logic vector_fetch_ack = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic irq_pin_n;
	logic irq_request;
	logic pending_flag;
	logic pin_level;
	logic [15:0] vector_hi_addr;
	logic [15:0] vector_lo_addr;
	int err_count = 0;
	int compares = 0;

	// The clock toggles every 4 ns, half of its 8 ns period.
	always #4 core_clk = ~core_clk;

	eil_src_model u_eil_src_model (.drive_low(drive_low), .irq_pin_n(irq_pin_n));

	eil_top u_eil_top (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
		.irq_pin_n(irq_pin_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.break_state(break_state), .vector_fetch_ack(vector_fetch_ack),
		.irq_request(irq_request), .pending_flag(pending_flag), .pin_level(pin_level),
		.vector_hi_addr(vector_hi_addr), .vector_lo_addr(vector_lo_addr));

	// Compares a seen value against the expected one and counts both.
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One-cycle write strobe.
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	// One-cycle read strobe; the data stand only in the following cycle.
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk({8'h00, reg_rdata}, {8'h00, exp});
	endtask

	// Moves the pin and waits out the synchroniser and the latch.
	task pin(input logic low);
		@(posedge core_clk);
		drive_low <= low;
		repeat (6) @(posedge core_clk);
		#1;
	endtask

	// Processor vector fetch acknowledge pulse.
	task fetch;
		@(posedge core_clk);
		vector_fetch_ack <= 1'b1;
		@(posedge core_clk);
		vector_fetch_ack <= 1'b0;
		#1;
	endtask

	task flag(input logic p, input logic r);
		chk({14'h0, pending_flag, irq_request}, {14'h0, p, r});
	endtask

	task test_done;
		if (err_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Watchdog well beyond the roughly 160 cycles the tests need.
	initial
	begin
		#40000;
		err_count++;
		test_done;
	end

	// Main sequence.
	initial
	begin
		repeat (10) @(posedge core_clk);
		resetn <= 1'b1;
		#1;
		chk(vector_hi_addr, 16'hFFFA);
		chk(vector_lo_addr, 16'hFFFB);
		chk({15'h0, pin_level}, 16'h0001);
		rd(EIL_OFS_STATUS, 8'h00);
		rd(EIL_OFS_BREAK, 8'h00);
		wr(8'h02, 8'hFF);
		rd(8'h02, 8'h00);
		// A frozen clock enable holds off sampling; the edge lands once it runs again.
		clk_en <= 1'b0;
		pin(1'b1);
		chk({15'h0, pin_level}, 16'h0001);
		flag(1'b0, 1'b0);
		clk_en <= 1'b1;
		// Edge mode: set, software clear with pin still low, rising edge ignored.
		pin(1'b1);
		flag(1'b1, 1'b1);
		chk({15'h0, pin_level}, 16'h0000);
		rd(EIL_OFS_STATUS, 8'h08);
		wr(EIL_OFS_STATUS, 8'h04);
		flag(1'b0, 1'b0);
		pin(1'b0);
		flag(1'b0, 1'b0);
		pin(1'b1);
		flag(1'b1, 1'b1);
		fetch;
		flag(1'b0, 1'b0);
		pin(1'b0);
		// Masked request stays visible to polling.
		wr(EIL_OFS_STATUS, 8'h02);
		pin(1'b1);
		flag(1'b1, 1'b0);
		rd(EIL_OFS_STATUS, 8'h0A);
		wr(EIL_OFS_STATUS, 8'h06);
		flag(1'b0, 1'b0);
		rd(EIL_OFS_STATUS, 8'h02);
		pin(1'b0);
		// Level mode: acknowledge first, then pin high; and the other order.
		wr(EIL_OFS_STATUS, 8'h01);
		rd(EIL_OFS_STATUS, 8'h01);
		pin(1'b1);
		fetch;
		flag(1'b1, 1'b1);
		pin(1'b0);
		flag(1'b0, 1'b0);
		pin(1'b1);
		pin(1'b0);
		flag(1'b1, 1'b1);
		wr(EIL_OFS_STATUS, 8'h05);
		flag(1'b0, 1'b0);
		// Break state protects the latch until break clearing is enabled.
		wr(EIL_OFS_STATUS, 8'h00);
		@(posedge core_clk);
		break_state <= 1'b1;
		pin(1'b1);
		wr(EIL_OFS_STATUS, 8'h04);
		flag(1'b1, 1'b1);
		wr(EIL_OFS_BREAK, 8'h80);
		rd(EIL_OFS_BREAK, 8'h80);
		wr(EIL_OFS_STATUS, 8'h04);
		flag(1'b0, 1'b0);
		@(posedge core_clk);
		break_state <= 1'b0;
		pin(1'b0);
		flag(1'b0, 1'b0);
		// Reset in mid-run clears a held level request with the pin low.
		wr(EIL_OFS_BREAK, 8'h00);
		wr(EIL_OFS_STATUS, 8'h03);
		pin(1'b1);
		flag(1'b1, 1'b0);
		@(posedge core_clk);
		resetn <= 1'b0;
		@(posedge core_clk);
		#1;
		flag(1'b0, 1'b0);
		drive_low <= 1'b0;
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		rd(EIL_OFS_STATUS, 8'h00);
		test_done;
	end
endmodule
